// *** tb/pmon_host.sv ***
module pmon_host (
    input  logic        clk,
    input  logic [23:0] reg_rdata,
    input  logic        reg_rvalid,
    output logic [5:0]  reg_addr,
    output logic        reg_rd,
    output logic        reg_wr,
    output logic [15:0] reg_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_addr  = 6'h3f;
        reg_rd    = 1'b0;
        reg_wr    = 1'b0;
        reg_wdata = 16'h0000;
    end
    // ----------------------------------------------------------------
    // Accesses
    // ----------------------------------------------------------------
    // Released lines flip, so a stale value is never taken for a live one
    task automatic rd(input logic [5:0] a, output logic [23:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_addr <= ~a;
        reg_rd   <= 1'b0;
        #1;
        d = (reg_rvalid === 1'b1) ? reg_rdata : 24'hxxxxxx;
    endtask : rd
    task automatic wr(input logic [5:0] a, input logic [15:0] v);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_addr  <= ~a;
        reg_wdata <= ~v;
        reg_wr    <= 1'b0;
        #1;
    endtask : wr
endmodule : pmon_host

// *** tb/tb_top.sv ***
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pmon_pkg::*;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic            clk;
    logic            reset_n;
    logic            ce;
    logic [4:0]      ev;
    pmon_sample_type raw_s;
    pmon_sample_type avg_s;
    pmon_limit_type  lim;
    logic [23:0]     rdata;
    logic            rvalid;
    logic [5:0]      addr;
    logic            rd;
    logic            wr;
    logic [15:0]     wdata;
    logic            oe_n;
    logic            alert_pin;
    int              fail_count;
    int              compares;
    int              cycles;
    pmon_results_alert i_pmon_results_alert (
        .clk          (clk),
        .reset_n      (reset_n),
        .ce           (ce),
        .reg_addr     (addr),
        .reg_rd       (rd),
        .reg_wr       (wr),
        .reg_wdata    (wdata),
        .reg_rdata    (rdata),
        .reg_rvalid   (rvalid),
        .raw_valid    (ev[0]),
        .raw_sample   (raw_s),
        .avg_done     (ev[1]),
        .avg_sample   (avg_s),
        .math_ovf     (ev[2]),
        .conv_trigger (ev[3]),
        .checksum_err (ev[4]),
        .limits       (lim),
        .alert_out    (alert_pin),
        .alert_oe_n   (oe_n)
    );
    pmon_host i_pmon_host (
        .clk        (clk),
        .reg_rdata  (rdata),
        .reg_rvalid (rvalid),
        .reg_addr   (addr),
        .reg_rd     (rd),
        .reg_wr     (wr),
        .reg_wdata  (wdata)
    );
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Quiet sample for k=6, otherwise one limit broken (flag k+2)
    function automatic pmon_sample_type smp(input int k);
        pmon_sample_type s;
        s = {16'h0000, 16'h0100, 16'h0000, 16'h0000, 24'h000000};
        case (k)
            5: s.temp = 16'h1010;
            4: s.shunt = 16'h1001;
            3: s.shunt = 16'hefff;
            2: s.bus = 16'h2001;
            1: s.bus = 16'h000f;
            0: s.power = 24'h010001;
            default: ;
        endcase
        return s;
    endfunction : smp
    function automatic logic [23:0] dg(input logic [3:0] c, input logic o,
                                       input logic [5:0] l, input logic v, input logic m);
        return {8'h00, c, 2'b00, o, 1'b0, l, v, m};
    endfunction : dg
    task automatic chk(input string n, input logic [23:0] e, input logic [23:0] s);
        compares++;
        if (s !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic rdc(input logic [5:0] a, input logic [23:0] e, input string n);
        logic [23:0] d;
        i_pmon_host.rd(a, d);
        chk(n, e, d);
    endtask : rdc
    task automatic po(input logic e);
        chk("alert_oe_n", {23'h000000, e}, {23'h000000, oe_n});
        chk("alert_out", 24'h000000, {23'h000000, alert_pin});
    endtask : po
    // Event taken at the second edge, settled state seen 1 ns later
    task automatic fire(input logic [4:0] m, input pmon_sample_type r, input pmon_sample_type a);
        @(posedge clk);
        ev    <= m;
        raw_s <= r;
        avg_s <= a;
        @(posedge clk);
        ev    <= 5'h00;
        #1;
    endtask : fire
    task automatic report_and_stop;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        for (int a = 4; a <= 8; a++) rdc(6'(a), 24'h000000, "result");
        rdc(PMON_ADDR_DIAG, dg(4'h0, 1'h0, 6'h00, 1'h0, 1'h1), "diag");
        rdc(6'h3f, 24'h000000, "unmapped");
        po(1'b1);
    endtask : t_reset
    task automatic t_results;
        fire(5'h01, smp(6), {16'h8001, 16'h8005, 16'h123f, 16'hfedc, 24'habcdef});
        rdc(PMON_ADDR_SHUNT, 24'h000000, "shunt_raw");
        fire(5'h02, smp(6), {16'h8001, 16'h8005, 16'h123f, 16'hfedc, 24'habcdef});
        rdc(PMON_ADDR_SHUNT, 24'h008001, "shunt");
        rdc(PMON_ADDR_BUS, 24'h000000, "bus");
        rdc(PMON_ADDR_TEMP, 24'h001230, "temp");
        rdc(PMON_ADDR_CURR, 24'h00fedc, "current");
        rdc(PMON_ADDR_POWER, 24'habcdef, "power");
        i_pmon_host.wr(PMON_ADDR_SHUNT, 16'h5555);
        rdc(PMON_ADDR_SHUNT, 24'h008001, "shunt_ro");
    endtask : t_results
    task automatic t_limits;
        fire(5'h08, smp(6), smp(6));
        rdc(PMON_ADDR_DIAG, dg(4'h0, 1'h0, 6'h00, 1'h0, 1'h1), "ready_on_alert_enable_trig");
        for (int k = 0; k < 6; k++) begin
            fire(5'h01, smp(k), smp(6));
            po(1'b0);
            rdc(PMON_ADDR_DIAG, dg(4'h0, 1'h0, 6'(1 << k), 1'h0, 1'h1), "flag");
            fire(5'h01, smp(6), smp(6));
            po(1'b1);
            rdc(PMON_ADDR_DIAG, dg(4'h0, 1'h0, 6'h00, 1'h0, 1'h1), "idle");
        end
    endtask : t_limits
    task automatic t_latch;
        i_pmon_host.wr(PMON_ADDR_DIAG, 16'ha000);
        fire(5'h01, smp(4), smp(6));
        rdc(PMON_ADDR_DIAG, dg(4'ha, 1'h0, 6'h00, 1'h0, 1'h1), "slow_raw");
        fire(5'h02, smp(6), smp(4));
        po(1'b0);
        fire(5'h02, smp(6), smp(6));
        po(1'b0);
        rdc(PMON_ADDR_DIAG, dg(4'ha, 1'h0, 6'h10, 1'h1, 1'h1), "latched");
        rdc(PMON_ADDR_DIAG, dg(4'ha, 1'h0, 6'h00, 1'h0, 1'h1), "rd_clear");
        po(1'b1);
        fire(5'h02, smp(6), smp(6));
        fire(5'h08, smp(6), smp(6));
        rdc(PMON_ADDR_DIAG, dg(4'ha, 1'h0, 6'h00, 1'h0, 1'h1), "trig_clear");
    endtask : t_latch
    task automatic t_pol;
        i_pmon_host.wr(PMON_ADDR_DIAG, 16'h1000);
        fire(5'h02, smp(6), smp(6));
        po(1'b0);
        i_pmon_host.wr(PMON_ADDR_DIAG, 16'h5000);
        fire(5'h02, smp(6), smp(6));
        po(1'b1);
        fire(5'h08, smp(6), smp(6));
        po(1'b0);
    endtask : t_pol
    task automatic t_ovf_trim;
        fire(5'h04, smp(6), smp(6));
        rdc(PMON_ADDR_DIAG, dg(4'h5, 1'h1, 6'h00, 1'h0, 1'h1), "ovf");
        rdc(PMON_ADDR_DIAG, dg(4'h5, 1'h1, 6'h00, 1'h0, 1'h1), "ovf_hold");
        fire(5'h08, smp(6), smp(6));
        rdc(PMON_ADDR_DIAG, dg(4'h5, 1'h0, 6'h00, 1'h0, 1'h1), "ovf_clear");
        fire(5'h10, smp(6), smp(6));
        rdc(PMON_ADDR_DIAG, dg(4'h5, 1'h0, 6'h00, 1'h0, 1'h0), "trim");
    endtask : t_ovf_trim
    // Every event lands while the enable is low, so nothing may move
    task automatic t_freeze;
        @(posedge clk);
        ce <= 1'b0;
        fire(5'h1f, smp(4), smp(4));
        @(posedge clk);
        ce <= 1'b1;
        rdc(PMON_ADDR_SHUNT, 24'h000000, "frozen_res");
        rdc(PMON_ADDR_DIAG, dg(4'h5, 1'h0, 6'h00, 1'h0, 1'h0), "frozen_diag");
        po(1'b0);
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        rdc(PMON_ADDR_DIAG, dg(4'h0, 1'h0, 6'h00, 1'h0, 1'h1), "reset_again");
        po(1'b1);
    endtask : t_freeze
    // ----------------------------------------------------------------
    // Run
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Whole run is about 150 cycles; the ceiling leaves ample margin
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            fail_count++;
            report_and_stop();
        end
    end
    initial begin
        reset_n    = 1'b0;
        ce         = 1'b1;
        ev         = 5'h00;
        raw_s      = smp(6);
        avg_s      = smp(6);
        lim        = {16'h1000, 16'hf000, 16'h2000, 16'h0010, 16'h1000, 16'h0100};
        fail_count = 0;
        compares   = 0;
        cycles     = 0;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        t_reset();
        t_results();
        t_limits();
        t_latch();
        t_pol();
        t_ovf_trim();
        t_freeze();
        report_and_stop();
    end
endmodule : tb_top

// *** verilog/pmon_alert_drive.sv ***
module pmon_alert_drive (
    input  logic [5:0] lim,
    input  logic       ready_on_alert_enable,
    input  logic       ready_on_alert_enable_en,
    input  logic       polarity,
    output logic       drive_low
);
    import pmon_pkg::*;

    logic active;

    always_comb begin
        active    = (|lim) | (ready_on_alert_enable_en & ready_on_alert_enable);
        // Open drain: inverted polarity pulls low while idle
        drive_low = active ^ polarity;
    end

endmodule : pmon_alert_drive

// *** verilog/pmon_limit_cmp.sv ***
module pmon_limit_cmp (
    input  pmon_pkg::pmon_sample_type sample,
    input  pmon_pkg::pmon_limit_type  limit,
    output logic [5:0]                cond
);
    import pmon_pkg::*;

    function automatic logic gt_s(input logic [15:0] a, input logic [15:0] b);
        gt_s = $signed(a) > $signed(b);
    endfunction : gt_s

    always_comb begin
        cond                   = '0;
        // Temperature limit sits in the same bit field as the result
        cond[PMON_L_TEMP]      = gt_s(sample.temp, limit.temp_limit);
        cond[PMON_L_SH_OVER]   = gt_s(sample.shunt, limit.shunt_over);
        cond[PMON_L_SH_UNDER]  = gt_s(limit.shunt_under, sample.shunt);
        cond[PMON_L_BUS_OVER]  = sample.bus > limit.bus_over;
        cond[PMON_L_BUS_UNDER] = sample.bus < limit.bus_under;
        // Limit counts in steps of 256 power LSBs
        cond[PMON_L_POWER]     = sample.power > {limit.power_limit, PMON_PWR_PAD};
    end

endmodule : pmon_limit_cmp

// *** verilog/pmon_pkg.sv ***
package pmon_pkg;

    // ----------------------------------------------------------------
    // Register map, word offsets
    // ----------------------------------------------------------------
    localparam logic [5:0] PMON_ADDR_SHUNT = 6'h04;
    localparam logic [5:0] PMON_ADDR_BUS   = 6'h05;
    localparam logic [5:0] PMON_ADDR_TEMP  = 6'h06;
    localparam logic [5:0] PMON_ADDR_CURR  = 6'h07;
    localparam logic [5:0] PMON_ADDR_POWER = 6'h08;
    localparam logic [5:0] PMON_ADDR_DIAG  = 6'h0b;

    // ----------------------------------------------------------------
    // Diagnostic register layout
    // ----------------------------------------------------------------
    localparam int         PMON_CTRL_LSB    = 12;
    localparam int         PMON_CTRL_MSB    = 15;
    localparam int         PMON_OVF_BIT     = 9;
    localparam int         PMON_LIM_LSB     = 2;
    localparam int         PMON_LIM_MSB     = 7;
    localparam int         PMON_READY_ON_ALERT_ENABLE_BIT    = 1;
    localparam int         PMON_MEM_BIT     = 0;
    localparam logic [3:0] PMON_CTRL_RESET  = 4'h0;
    localparam logic       PMON_MEM_RESET   = 1'b1;

    // Control nibble positions (within bits 15..12)
    localparam int         PMON_C_LATCH     = 3;
    localparam int         PMON_C_READY_ON_ALERT_ENABLE_EN   = 2;
    localparam int         PMON_C_SLOW      = 1;
    localparam int         PMON_C_POL       = 0;

    // Limit flag vector positions (flag bit minus two)
    localparam int         PMON_L_TEMP      = 5;
    localparam int         PMON_L_SH_OVER   = 4;
    localparam int         PMON_L_SH_UNDER  = 3;
    localparam int         PMON_L_BUS_OVER  = 2;
    localparam int         PMON_L_BUS_UNDER = 1;
    localparam int         PMON_L_POWER     = 0;

    // Temperature field and power limit scale
    localparam int         PMON_TEMP_LSB    = 4;
    localparam logic [3:0] PMON_TEMP_PAD    = 4'h0;
    localparam logic [7:0] PMON_PWR_PAD     = 8'h00;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [15:0] shunt;
        logic [15:0] bus;
        logic [15:0] temp;
        logic [15:0] current;
        logic [23:0] power;
    } pmon_sample_type;

    typedef struct packed {
        logic [15:0] shunt_over;
        logic [15:0] shunt_under;
        logic [15:0] bus_over;
        logic [15:0] bus_under;
        logic [15:0] temp_limit;
        logic [15:0] power_limit;
    } pmon_limit_type;

    typedef struct packed {
        pmon_sample_type res;
        logic [3:0]      ctrl;
        logic [5:0]      lim;
        logic            ready_on_alert_enable;
        logic            ovf;
        logic            mem;
        logic [23:0]     rdata;
        logic            rvalid;
        logic            alert_oe_n;
        logic            alert_out;
    } pmon_state_type;

endpackage : pmon_pkg

// *** verilog/pmon_results_alert.sv ***
module pmon_results_alert #(
    parameter int ADDR_W = 6
) (
    input  logic                      clk,
    input  logic                      reset_n,
    input  logic                      ce,
    input  logic [ADDR_W-1:0]         reg_addr,
    input  logic                      reg_rd,
    input  logic                      reg_wr,
    input  logic [15:0]               reg_wdata,
    output logic [23:0]               reg_rdata,
    output logic                      reg_rvalid,
    input  logic                      raw_valid,
    input  pmon_pkg::pmon_sample_type raw_sample,
    input  logic                      avg_done,
    input  pmon_pkg::pmon_sample_type avg_sample,
    input  logic                      math_ovf,
    input  logic                      conv_trigger,
    input  logic                      checksum_err,
    input  pmon_pkg::pmon_limit_type  limits,
    output logic                      alert_out,
    output logic                      alert_oe_n
);
    import pmon_pkg::*;

    // ----------------------------------------------------------------
    // Elaboration check
    // ----------------------------------------------------------------
    if (ADDR_W < 6) begin : g_addr_chk
        $error("ADDR_W too narrow for register map");
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    pmon_state_type  q_reg;
    pmon_state_type  q_next;
    pmon_sample_type cmp_sample;
    logic [5:0]      cond;
    logic            cmp_ev;
    logic            diag_rd;
    logic            diag_wr;
    logic            drive_low;

    function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [5:0] off);
        addr_hit = a == ADDR_W'(off);
    endfunction : addr_hit

    // ----------------------------------------------------------------
    // Compare source selection
    // ----------------------------------------------------------------
    always_comb begin
        if (q_reg.ctrl[PMON_C_SLOW]) begin
            cmp_sample = avg_sample;
            cmp_ev     = avg_done;
        end else begin
            cmp_sample = raw_sample;
            cmp_ev     = raw_valid;
        end
        diag_rd = reg_rd && addr_hit(reg_addr, PMON_ADDR_DIAG);
        diag_wr = reg_wr && addr_hit(reg_addr, PMON_ADDR_DIAG);
    end

    pmon_limit_cmp u_cmp (
        .sample (cmp_sample),
        .limit  (limits),
        .cond   (cond)
    );

    pmon_alert_drive u_drive (
        .lim       (q_next.lim),
        .ready_on_alert_enable      (q_next.ready_on_alert_enable),
        .ready_on_alert_enable_en   (q_next.ctrl[PMON_C_READY_ON_ALERT_ENABLE_EN]),
        .polarity  (q_next.ctrl[PMON_C_POL]),
        .drive_low (drive_low)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        q_next        = q_reg;
        q_next.rvalid = 1'b0;

        // Results move only once the averaged set is complete
        if (avg_done) begin
            q_next.res.shunt   = avg_sample.shunt;
            // Clamp guards against a stray negative code
            q_next.res.bus     = avg_sample.bus[15] ? '0 : avg_sample.bus;
            q_next.res.temp    = {avg_sample.temp[15:PMON_TEMP_LSB], PMON_TEMP_PAD};
            q_next.res.current = avg_sample.current;
            q_next.res.power   = avg_sample.power;
        end

        // Limit flags
        if (q_reg.ctrl[PMON_C_LATCH]) begin
            if (diag_rd) begin
                q_next.lim = '0;
            end
            if (cmp_ev) begin
                q_next.lim = q_next.lim | cond;
            end
        end else if (cmp_ev) begin
            q_next.lim = cond;
        end

        // Conversion complete: set wins over either clear
        if (conv_trigger || (q_reg.ctrl[PMON_C_LATCH] && diag_rd)) begin
            q_next.ready_on_alert_enable = 1'b0;
        end
        if (avg_done) begin
            q_next.ready_on_alert_enable = 1'b1;
        end

        // Arithmetic overflow
        if (conv_trigger) begin
            q_next.ovf = 1'b0;
        end
        if (math_ovf) begin
            q_next.ovf = 1'b1;
        end

        // Trim status stays low until reset
        if (checksum_err) begin
            q_next.mem = 1'b0;
        end

        // Only the control nibble is writable
        if (diag_wr) begin
            q_next.ctrl = reg_wdata[PMON_CTRL_MSB:PMON_CTRL_LSB];
        end

        // Read data shows values before any read side effect
        if (reg_rd) begin
            q_next.rvalid = 1'b1;
            q_next.rdata  = '0;
            if (addr_hit(reg_addr, PMON_ADDR_SHUNT)) begin
                q_next.rdata[15:0] = q_reg.res.shunt;
            end else if (addr_hit(reg_addr, PMON_ADDR_BUS)) begin
                q_next.rdata[15:0] = q_reg.res.bus;
            end else if (addr_hit(reg_addr, PMON_ADDR_TEMP)) begin
                q_next.rdata[15:0] = q_reg.res.temp;
            end else if (addr_hit(reg_addr, PMON_ADDR_CURR)) begin
                q_next.rdata[15:0] = q_reg.res.current;
            end else if (addr_hit(reg_addr, PMON_ADDR_POWER)) begin
                q_next.rdata = q_reg.res.power;
            end else if (diag_rd) begin
                // Bits 11, 10 and 8 stay zero
                q_next.rdata[PMON_CTRL_MSB:PMON_CTRL_LSB] = q_reg.ctrl;
                q_next.rdata[PMON_OVF_BIT]                = q_reg.ovf;
                q_next.rdata[PMON_LIM_MSB:PMON_LIM_LSB]   = q_reg.lim;
                q_next.rdata[PMON_READY_ON_ALERT_ENABLE_BIT]               = q_reg.ready_on_alert_enable;
                q_next.rdata[PMON_MEM_BIT]                = q_reg.mem;
            end
        end

        // Pin reflects the flags as they will stand next cycle
        q_next.alert_out  = 1'b0;
        q_next.alert_oe_n = ~drive_low;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            q_reg            <= '0;
            q_reg.ctrl       <= PMON_CTRL_RESET;
            q_reg.mem        <= PMON_MEM_RESET;
            q_reg.alert_oe_n <= 1'b1;
        end else if (ce) begin
            q_reg <= q_next;
        end
    end

    always_comb begin
        reg_rdata  = q_reg.rdata;
        reg_rvalid = q_reg.rvalid;
        alert_out  = q_reg.alert_out;
        alert_oe_n = q_reg.alert_oe_n;
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    latch_hold_a: assert property (
        (q_reg.ctrl[PMON_C_LATCH] && $past(q_reg.ctrl[PMON_C_LATCH])
         && (|($past(q_reg.lim) & ~q_reg.lim)))
        |-> $past(diag_rd && ce))
        else $error("latched flag dropped without a read");

    transp_follow_a: assert property (
        ce && !q_reg.ctrl[PMON_C_LATCH] && cmp_ev
        |=> q_reg.lim == $past(cond))
        else $error("transparent flags do not follow compare");

    latch_clear_a: assert property (
        ce && q_reg.ctrl[PMON_C_LATCH] && diag_rd && !cmp_ev
        |=> q_reg.lim == '0)
        else $error("latched flags not cleared by read");

    ovf_trigger_a: assert property (
        ce && conv_trigger && !math_ovf |=> !q_reg.ovf)
        else $error("overflow flag not cleared by trigger");

    ovf_hold_a: assert property (
        q_reg.ovf && !$past(conv_trigger && ce) |-> $past(q_reg.ovf) || $past(math_ovf))
        else $error("overflow flag changed without cause");

    temp_field_a: assert property (
        q_reg.res.temp[PMON_TEMP_LSB-1:0] == PMON_TEMP_PAD)
        else $error("temperature low bits not zero");

    bus_sign_a: assert property (
        !q_reg.res.bus[15])
        else $error("bus result negative");

    mem_status_a: assert property (
        ce && checksum_err |=> !q_reg.mem ##1 !q_reg.mem)
        else $error("trim status not held low");

    ready_on_alert_enable_set_a: assert property (
        ce && avg_done |=> q_reg.ready_on_alert_enable && q_reg.res.current == $past(avg_sample.current))
        else $error("conversion flag or result not updated");

    pin_level_a: assert property (
        q_reg.alert_oe_n == !((|q_reg.lim
            | (q_reg.ctrl[PMON_C_READY_ON_ALERT_ENABLE_EN] & q_reg.ready_on_alert_enable)) ^ q_reg.ctrl[PMON_C_POL]))
        else $error("alert pin disagrees with flags");

    rsvd_zero_a: assert property (
        ce && diag_rd |=> reg_rdata[PMON_CTRL_LSB-1 -: 2] == 2'h0
            && !reg_rdata[PMON_OVF_BIT-1] && reg_rvalid)
        else $error("reserved diagnostic bits nonzero");

    results_hold_a: assert property (
        !(ce && avg_done) |=> q_reg.res == $past(q_reg.res))
        else $error("results moved without a completed average");

    result_copy_a: assert property (
        ce && avg_done |=> q_reg.res.shunt == $past(avg_sample.shunt)
            && q_reg.res.power == $past(avg_sample.power))
        else $error("shunt or power result not taken from average");

    bus_copy_a: assert property (
        ce && avg_done && ($signed(avg_sample.bus) >= 0)
        |=> q_reg.res.bus == $past(avg_sample.bus))
        else $error("bus result not taken from average");

    power_read_a: assert property (
        ce && reg_rd && addr_hit(reg_addr, PMON_ADDR_POWER)
        |=> reg_rdata == $past(q_reg.res.power))
        else $error("power read lost upper bits");

    // Whole state compared, so a stray strobe leaking past the enable shows
    ce_freeze_a: assert property (
        !ce |=> q_reg == $past(q_reg))
        else $error("state moved while clock enable low");

    latch_set_a: assert property (
        ce && q_reg.ctrl[PMON_C_LATCH] && cmp_ev
        |=> (q_reg.lim & $past(cond)) == $past(cond))
        else $error("latched compare hit not recorded");

    slow_hold_a: assert property (
        ce && q_reg.ctrl[PMON_C_SLOW] && !avg_done && !diag_rd
        |=> q_reg.lim == $past(q_reg.lim))
        else $error("slow compare moved flags without an average");

    ctrl_write_a: assert property (
        ce && diag_wr |=> q_reg.ctrl == $past(reg_wdata[PMON_CTRL_MSB:PMON_CTRL_LSB]))
        else $error("control nibble not written");

    ctrl_keep_a: assert property (
        !(ce && diag_wr) |=> q_reg.ctrl == $past(q_reg.ctrl))
        else $error("control nibble changed without a write");

    ovf_set_a: assert property (
        ce && math_ovf |=> q_reg.ovf)
        else $error("overflow flag not set");

    diag_view_a: assert property (
        ce && diag_rd |=> reg_rdata[PMON_LIM_MSB:PMON_LIM_LSB] == $past(q_reg.lim))
        else $error("diagnostic read lost flags before clear");

    ready_on_alert_enable_trig_a: assert property (
        ce && conv_trigger && !avg_done |=> !q_reg.ready_on_alert_enable)
        else $error("conversion flag not cleared by trigger");

    ready_on_alert_enable_read_a: assert property (
        ce && q_reg.ctrl[PMON_C_LATCH] && diag_rd && !avg_done |=> !q_reg.ready_on_alert_enable)
        else $error("latched conversion flag not cleared by read");

    ready_on_alert_enable_keep_a: assert property (
        ce && !q_reg.ctrl[PMON_C_LATCH] && !conv_trigger
        |=> q_reg.ready_on_alert_enable || !$past(q_reg.ready_on_alert_enable))
        else $error("transparent conversion flag cleared without trigger");

    mem_sticky_a: assert property (
        !$past(q_reg.mem) |-> !q_reg.mem)
        else $error("trim status returned high without reset");

    rd_answer_a: assert property (
        ce |=> reg_rvalid == $past(reg_rd))
        else $error("read answer not one cycle after request");

    // ----------------------------------------------------------------
    // Coverage
    // ----------------------------------------------------------------
    slow_flag_c: cover property (
        ce && q_reg.ctrl[PMON_C_SLOW] && avg_done && (|cond));
    freeze_c: cover property (
        !ce && avg_done);

    latch_read_c: cover property (
        q_reg.ctrl[PMON_C_LATCH] && (|q_reg.lim) && diag_rd && ce);
    inv_alert_c: cover property (
        q_reg.ctrl[PMON_C_POL] && !q_reg.alert_oe_n);
    ready_on_alert_enable_pin_c: cover property (
        q_reg.ctrl[PMON_C_READY_ON_ALERT_ENABLE_EN] && q_reg.ready_on_alert_enable && (q_reg.lim == '0)
        && (q_reg.alert_oe_n == q_reg.ctrl[PMON_C_POL]));

endmodule : pmon_results_alert
